// File: common/sut_pkg.sv
// constants and types for the user-bit buffer and transmitter control registers
package sut_pkg;
  // register addresses on the control port
  localparam logic [6:0] SUT_ADDR_RX_BUF = 7'h0b;
  localparam logic [6:0] SUT_ADDR_TX_CTL = 7'h0c;
  // writable bit masks, reserved bits excluded
  localparam logic [7:0] SUT_RX_BUF_MASK = 8'h3f;
  localparam logic [7:0] SUT_TX_CTL_MASK = 8'h7f;
  // reset values
  localparam logic [5:0] SUT_RX_BUF_RST = 6'h00;
  localparam logic [6:0] SUT_TX_CTL_RST = 7'h00;
  // receive buffer config field positions
  localparam int SUT_TAPE_ID_BIT = 5;
  localparam int SUT_SPLIT_BIT   = 4;
  localparam int SUT_CS_MODE_BIT = 3;
  localparam int SUT_UB_MODE_LSB = 1;
  localparam int SUT_UB_SIZE_BIT = 0;
  // transmit control field positions
  localparam int SUT_TX_VAL_BIT   = 6;
  localparam int SUT_TX_RATIO_LSB = 3;
  localparam int SUT_TX_CLK_LSB   = 1;
  localparam int SUT_TX_RUN_BIT   = 0;
  // last user buffer bit index, last channel-status frame index, compared status bit count
  localparam logic [9:0] SUT_UB_SMALL_LAST = 10'h17f;
  localparam logic [9:0] SUT_UB_LARGE_LAST = 10'h2ff;
  localparam logic [7:0] SUT_CS_LAST_FRAME = 8'hbf;
  localparam logic [7:0] SUT_CS_CMP_BITS   = 8'h28;
  // ratio multipliers
  localparam logic [2:0] SUT_MUL_1 = 3'h1;
  localparam logic [2:0] SUT_MUL_2 = 3'h2;
  localparam logic [2:0] SUT_MUL_4 = 3'h4;

  typedef enum logic [1:0] {
    SUT_UB_OFF    = 2'b00,
    SUT_UB_DOUBLE = 2'b01,
    SUT_UB_FORMAT = 2'b10,
    SUT_UB_RSVD   = 2'b11
  } sut_ub_mode_t;

  typedef struct packed {
    logic [5:0]  cfg_rx;
    logic [6:0]  cfg_tx;
    logic [7:0]  rdata;
    logic        synced;
    logic [9:0]  cnt;
    logic        ubuf;
    logic        u_wr;
    logic [9:0]  u_addr;
    logic        u_chb;
    logic        u_data;
    logic        u_irq;
    logic        first_bit;
    logic        prev_first;
    logic        have_prev;
    logic        cs_sync;
    logic [7:0]  fcnt;
    logic [39:0] cs_cur;
    logic [39:0] cs_prev;
    logic        cs_prev_ok;
    logic        cs_flag;
    logic        tx_val;
  } sut_state_t;
endpackage : sut_pkg

// File: rtl/sut_spdif_ctl.sv
// user-bit buffering, channel-status block flag and transmitter control registers
`timescale 1ns/100ps
`default_nettype none
module sut_spdif_ctl
  import sut_pkg::*;
(
  input  wire logic       CLK_I,
  input  wire logic       RST_N_I,
  input  wire logic [6:0] REG_ADDR_I,
  input  wire logic       REG_WR_I,
  input  wire logic       REG_RD_I,
  input  wire logic [7:0] REG_WDATA_I,
  output logic      [7:0] REG_RDATA_O,
  input  wire logic       RX_SUB_I,
  input  wire logic       RX_CHB_I,
  input  wire logic       RX_PRE_Z_I,
  input  wire logic       RX_USER_BIT_I,
  input  wire logic       RX_CS_BIT_I,
  input  wire logic       TAPE_CATEGORY_I,
  input  wire logic       CS_FLAG_CLR_I,
  output logic            USER_WR_O,
  output logic      [9:0] USER_WADDR_O,
  output logic            USER_WBUF_O,
  output logic            USER_WCHB_O,
  output logic            USER_WDATA_O,
  output logic            USER_IRQ_O,
  output logic            USER_FMT_PRO_O,
  output logic            RX_CS_BLOCK_FLAG_O,
  input  wire logic       TX_SUB_START_I,
  output logic            TX_VALIDITY_O,
  output logic      [2:0] TX_MUL_O,
  output logic      [2:0] TX_RX_MUL_O,
  output logic      [2:0] TX_CLK_SEL_O,
  output logic            TX_RUN_O
);
  sut_state_t   q;
  sut_state_t   next_q;
  sut_ub_mode_t ub_mode;
  logic         split;
  logic         professional_flag;
  logic         z_a;
  logic         blk_end;
  logic         cs_set;
  logic [9:0]   last;
  logic [9:0]   ub_base;
  logic [2:0]   ratio;

  // field views of the configuration registers
  assign ub_mode = sut_ub_mode_t'(q.cfg_rx[SUT_UB_MODE_LSB +: 2]);
  assign split   = q.cfg_rx[SUT_SPLIT_BIT];
  assign ratio   = q.cfg_tx[SUT_TX_RATIO_LSB +: 3];
  // professional flag is bit 0 of the last complete block
  assign professional_flag     = q.cs_prev_ok & q.cs_prev[0];
  assign z_a     = RX_SUB_I & RX_PRE_Z_I & ~RX_CHB_I;
  // fcnt counts A frames from Z inclusive, so a whole block reads one past the last index
  assign blk_end = z_a & q.cs_sync & (q.fcnt == SUT_CS_LAST_FRAME + 8'h01);
  // mode 1 compares only the leading five bytes
  assign cs_set  = blk_end & (~q.cfg_rx[SUT_CS_MODE_BIT] |
                   ~q.cs_prev_ok | (q.cs_cur != q.cs_prev));
  // format mode has no size choice, so it uses the short buffer
  assign last    = (ub_mode == SUT_UB_DOUBLE && q.cfg_rx[SUT_UB_SIZE_BIT]) ?
                   SUT_UB_LARGE_LAST : SUT_UB_SMALL_LAST;
  // user bit address restarts at every preamble Z
  assign ub_base = z_a ? 10'h000 : q.cnt;

  // next-state logic for every register of the block
  always_comb
  begin
    next_q       = q;
    next_q.u_wr  = 1'b0;
    next_q.u_irq = 1'b0;
    next_q.rdata = 8'h00;
    // register port, reserved bits masked off
    if (REG_WR_I && REG_ADDR_I == SUT_ADDR_RX_BUF)
    begin
      next_q.cfg_rx = REG_WDATA_I[5:0] & SUT_RX_BUF_MASK[5:0];
    end
    else if (REG_WR_I && REG_ADDR_I == SUT_ADDR_TX_CTL)
    begin
      next_q.cfg_tx = REG_WDATA_I[6:0] & SUT_TX_CTL_MASK[6:0];
    end
    if (REG_RD_I && REG_ADDR_I == SUT_ADDR_RX_BUF)
    begin
      next_q.rdata = {2'b00, q.cfg_rx};
    end
    else if (REG_RD_I && REG_ADDR_I == SUT_ADDR_TX_CTL)
    begin
      next_q.rdata = {1'b0, q.cfg_tx};
    end
    // channel-status framing counts channel A subframes
    if (z_a)
    begin
      next_q.cs_sync   = 1'b1;
      next_q.fcnt      = 8'h01;
      next_q.cs_cur[0] = RX_CS_BIT_I;
      if (blk_end)
      begin
        next_q.cs_prev    = q.cs_cur;
        next_q.cs_prev_ok = 1'b1;
      end
    end
    else if (RX_SUB_I && !RX_CHB_I && q.cs_sync)
    begin
      // saturate so a stream that loses preamble Z never fakes a block end
      if (q.fcnt != 8'hff)
      begin
        next_q.fcnt = q.fcnt + 8'h01;
      end
      if (q.fcnt < SUT_CS_CMP_BITS)
      begin
        next_q.cs_cur[q.fcnt[5:0]] = RX_CS_BIT_I;
      end
    end
    // set beats a clear in the same cycle
    if (CS_FLAG_CLR_I)
    begin
      next_q.cs_flag = 1'b0;
    end
    if (cs_set)
    begin
      next_q.cs_flag = 1'b1;
    end
    // user bits: dropped when off or reserved, else written in order from Z
    if (ub_mode == SUT_UB_OFF || ub_mode == SUT_UB_RSVD)
    begin
      next_q.synced = 1'b0;
    end
    else if (RX_SUB_I && (q.synced || z_a))
    begin
      next_q.synced = 1'b1;
      next_q.u_wr   = 1'b1;
      next_q.u_data = RX_USER_BIT_I;
      // split halves the per-channel address and steers by channel
      next_q.u_addr = split ? {1'b0, ub_base[9:1]} : ub_base;
      next_q.u_chb  = split & RX_CHB_I;
      next_q.cnt    = ub_base + 10'h001;
      // swap shows on the first write after a full one, so the last bit stays put
      next_q.ubuf   = q.ubuf ^ (q.have_prev & (q.cnt == 10'h000));
      if (z_a)
      begin
        next_q.first_bit = RX_USER_BIT_I;
      end
      if (ub_base == last)
      begin
        // full: the next write goes to the other half of the double buffer
        next_q.cnt       = 10'h000;
        next_q.prev_first = q.first_bit;
        next_q.have_prev = 1'b1;
        if (ub_mode == SUT_UB_FORMAT && q.cfg_rx[SUT_TAPE_ID_BIT] &&
            !professional_flag && TAPE_CATEGORY_I)
        begin
          next_q.u_irq = ~q.have_prev | (q.first_bit != q.prev_first);
        end
        else
        begin
          next_q.u_irq = 1'b1;
        end
      end
    end
    // validity is sampled per subframe so it changes mid-subframe only when run is set or cleared
    if (TX_SUB_START_I && q.cfg_tx[SUT_TX_RUN_BIT])
    begin
      next_q.tx_val = q.cfg_tx[SUT_TX_VAL_BIT];
    end
  end

  // single state register
  always_ff @(posedge CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      q        <= '0;
      q.cfg_rx <= SUT_RX_BUF_RST;
      q.cfg_tx <= SUT_TX_CTL_RST;
    end
    else
    begin
      q <= next_q;
    end
  end

  // transmitter decodes; undefined ratio codes fall back to 1:1
  always_comb
  begin
    TX_MUL_O    = SUT_MUL_1;
    TX_RX_MUL_O = SUT_MUL_1;
    case (ratio)
      3'b001:  TX_RX_MUL_O = SUT_MUL_2;
      3'b010:  TX_RX_MUL_O = SUT_MUL_4;
      3'b101:  TX_MUL_O    = SUT_MUL_2;
      3'b110:  TX_MUL_O    = SUT_MUL_4;
      default: TX_MUL_O    = SUT_MUL_1;
    endcase
    case (q.cfg_tx[SUT_TX_CLK_LSB +: 2])
      2'b00:   TX_CLK_SEL_O = 3'h1;
      2'b01:   TX_CLK_SEL_O = 3'h2;
      2'b10:   TX_CLK_SEL_O = 3'h4;
      default: TX_CLK_SEL_O = 3'h0;
    endcase
  end

  // outputs from the state register; format flag gated by buffer mode, validity by run
  assign REG_RDATA_O        = q.rdata;
  assign USER_WR_O          = q.u_wr;
  assign USER_WADDR_O       = q.u_addr;
  assign USER_WBUF_O        = q.ubuf;
  assign USER_WCHB_O        = q.u_chb;
  assign USER_WDATA_O       = q.u_data;
  assign USER_IRQ_O         = q.u_irq;
  assign USER_FMT_PRO_O     = (ub_mode == SUT_UB_FORMAT) & professional_flag;
  assign RX_CS_BLOCK_FLAG_O = q.cs_flag;
  assign TX_VALIDITY_O      = q.tx_val & q.cfg_tx[SUT_TX_RUN_BIT];
  assign TX_RUN_O           = q.cfg_tx[SUT_TX_RUN_BIT];

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);

  rsvd_read_a: assert property (REG_RD_I && REG_ADDR_I == SUT_ADDR_RX_BUF |=>
    REG_RDATA_O[7:6] == 2'b00 && REG_RDATA_O[5:0] == $past(q.cfg_rx))
    else $error("receive config read back wrong");
  tx_write_a: assert property (REG_WR_I && REG_ADDR_I == SUT_ADDR_TX_CTL |=>
    q.cfg_tx == $past(REG_WDATA_I[6:0]))
    else $error("transmit control write lost");
  run_follow_a: assert property (REG_WR_I && REG_ADDR_I == SUT_ADDR_TX_CTL |=>
    TX_RUN_O == $past(REG_WDATA_I[0]))
    else $error("transmitter run does not follow enable");
  validity_copy_a: assert property (TX_SUB_START_I && TX_RUN_O |=>
    TX_VALIDITY_O == ($past(q.cfg_tx[SUT_TX_VAL_BIT]) & TX_RUN_O))
    else $error("validity bit not copied");
  ratio_slow_a: assert property (ratio == 3'b010 |-> TX_RX_MUL_O == 3'h4 &&
    TX_MUL_O == 3'h1)
    else $error("ratio 1:4 decoded wrong");
  ratio_fast_a: assert property (ratio == 3'b101 |-> TX_MUL_O == 3'h2 &&
    TX_RX_MUL_O == 3'h1)
    else $error("ratio 2:1 decoded wrong");
  clk_pll_a: assert property (q.cfg_tx[2:1] == 2'b10 |-> TX_CLK_SEL_O == 3'h4)
    else $error("pll clock not selected");
  ub_off_a: assert property (ub_mode == SUT_UB_OFF |=> !USER_WR_O)
    else $error("user bit written while buffer off");
  together_a: assert property (USER_WR_O && !$past(split) |-> !USER_WCHB_O)
    else $error("channel B split while stored together");
  small_size_a: assert property (USER_WR_O && $past(last) == SUT_UB_SMALL_LAST |->
    USER_WADDR_O <= SUT_UB_SMALL_LAST)
    else $error("user address beyond short buffer");
  cs_every_a: assert property (blk_end && !q.cfg_rx[SUT_CS_MODE_BIT] |=>
    RX_CS_BLOCK_FLAG_O)
    else $error("block flag missed");
  cs_same_a: assert property (blk_end && q.cfg_rx[SUT_CS_MODE_BIT] && q.cs_prev_ok &&
    q.cs_cur == q.cs_prev && !RX_CS_BLOCK_FLAG_O && !CS_FLAG_CLR_I |=> !RX_CS_BLOCK_FLAG_O)
    else $error("block flag set without change");
  pro_fmt_a: assert property (blk_end && ub_mode == SUT_UB_FORMAT && q.cs_cur[0] &&
    !REG_WR_I |=> USER_FMT_PRO_O)
    else $error("professional format not chosen");
  tape_quiet_a: assert property (ub_mode == SUT_UB_FORMAT && TAPE_CATEGORY_I &&
    q.cfg_rx[SUT_TAPE_ID_BIT] && !professional_flag && q.have_prev && q.first_bit == q.prev_first |=>
    !USER_IRQ_O)
    else $error("tape interrupt without start bit change");

  cs_block_c: cover property (blk_end ##1 RX_CS_BLOCK_FLAG_O);
  ub_swap_c:  cover property (USER_IRQ_O ##2 USER_WR_O);
  split_c:    cover property (USER_WR_O && USER_WCHB_O);
  tx_run_c:   cover property (TX_RUN_O && TX_VALIDITY_O);
endmodule : sut_spdif_ctl
`default_nettype wire

// File: test/sut_spdif_src.sv
// far-side receive stream source handing decoded subframes to the block
`timescale 1ns/100ps
`default_nettype none
module sut_spdif_src
(
  input  wire logic clk_i,
  output logic      sub_o,
  output logic      chb_o,
  output logic      pre_z_o,
  output logic      user_o,
  output logic      cs_o
);
  initial {sub_o, chb_o, pre_z_o, user_o, cs_o} = 5'h00;
  // one subframe per two cycles; lines carry inverted data between strobes
  task automatic put(input logic b, input logic z, input logic u, input logic c);
    @(negedge clk_i);
    {sub_o, chb_o, pre_z_o, user_o, cs_o} = {1'b1, b, z, u, c};
    @(negedge clk_i);
    {sub_o, chb_o, pre_z_o, user_o, cs_o} = {1'b0, ~b, ~z, ~u, ~c};
  endtask : put
  // frames from one preamble z, leading status bits taken from cs
  task automatic block(input int frames, input logic [39:0] cs);
    for (int f = 0; f < frames; f++)
    begin
      put(1'b0, f == 0, 1'($urandom), f < 40 ? cs[f] : 1'b0);
      put(1'b1, 1'b0, 1'($urandom), 1'b0);
    end
  endtask : block
endmodule : sut_spdif_src
`default_nettype wire

// File: test/spdif_user_buffer_tx_control_test.sv
// self-checking bench for the user-bit buffer and transmitter control registers
`timescale 1ns/100ps
`default_nettype none
module spdif_user_buffer_tx_control_test;
  import sut_pkg::*;
  logic        CLK_I, RST_N_I, wr, rd, clr, tx_start, tape;
  logic [6:0]  addr;
  logic [7:0]  wdata, rdata, q, d;
  logic        rx_sub, rx_chb, rx_z, rx_u, rx_cs, u_wr, u_chb, u_irq;
  logic        fmt_pro, cs_flag, tx_val, tx_run;
  logic        u_buf, u_dat, u_last, wb_last;
  logic        zq[$];
  logic [9:0]  u_addr, last_a;
  logic [2:0]  tx_mul, rx_mul, clk_sel, r;
  logic [39:0] cs_a, cs_b;
  int          err_count, checks, n_wr, n_irq, n_b, n_tog, m, ln, ew, c;
  int          mt[8] = '{1, 1, 1, 1, 1, 2, 4, 1};
  int          mr[8] = '{1, 2, 4, 1, 1, 1, 1, 1};
  logic [2:0]  codes[5] = '{3'h0, 3'h1, 3'h2, 3'h5, 3'h6};
  logic [7:0]  cfgs[5] = '{8'h02, 8'h03, 8'h00, 8'h12, 8'h04};
  int          frs[5] = '{192, 384, 192, 192, 192};

  sut_spdif_ctl uut (.CLK_I(CLK_I), .RST_N_I(RST_N_I), .REG_ADDR_I(addr), .REG_WR_I(wr),
    .REG_RD_I(rd), .REG_WDATA_I(wdata), .REG_RDATA_O(rdata), .RX_SUB_I(rx_sub),
    .RX_CHB_I(rx_chb), .RX_PRE_Z_I(rx_z), .RX_USER_BIT_I(rx_u), .RX_CS_BIT_I(rx_cs),
    .TAPE_CATEGORY_I(tape), .CS_FLAG_CLR_I(clr), .USER_WR_O(u_wr), .USER_WADDR_O(u_addr),
    .USER_WBUF_O(u_buf), .USER_WCHB_O(u_chb), .USER_WDATA_O(u_dat), .USER_IRQ_O(u_irq),
    .USER_FMT_PRO_O(fmt_pro), .RX_CS_BLOCK_FLAG_O(cs_flag), .TX_SUB_START_I(tx_start),
    .TX_VALIDITY_O(tx_val), .TX_MUL_O(tx_mul), .TX_RX_MUL_O(rx_mul),
    .TX_CLK_SEL_O(clk_sel), .TX_RUN_O(tx_run));
  sut_spdif_src src (.clk_i(CLK_I), .sub_o(rx_sub), .chb_o(rx_chb), .pre_z_o(rx_z),
    .user_o(rx_u), .cs_o(rx_cs));

  initial
  begin
    CLK_I = 1'b0;
    forever #5 CLK_I = ~CLK_I;
  end
  // tally of buffer writes seen at the ports
  always @(posedge CLK_I)
  begin
    if (u_wr === 1'b1) n_wr++;
    if (u_wr === 1'b1 && u_chb === 1'b1) n_b++;
    if (u_irq === 1'b1) n_irq++;
    if (u_irq === 1'b1) last_a = u_addr;
    // stored bit echoes the strobed one; the filling buffer holds until its last bit
    if (u_wr === 1'b1) chk(u_dat, u_last);
    if (u_irq === 1'b1) chk(u_buf, wb_last);
    if (u_wr === 1'b1 && u_buf !== wb_last) n_tog++;
    if (u_wr === 1'b1) wb_last = u_buf;
    if (rx_sub === 1'b1) u_last = rx_u;
    if (rx_sub === 1'b1 && rx_z === 1'b1 && rx_chb === 1'b0) zq.push_back(rx_u);
  end

  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    checks++;
    if (got !== exp) err_count++;
    if (got !== exp) $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
  endtask : chk
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : wrap_up
  task automatic do_reset;
    RST_N_I = 1'b0;
    repeat (3) @(negedge CLK_I);
    RST_N_I = 1'b1;
  endtask : do_reset
  // strobes raised at a falling edge, dropped one cycle later
  task automatic reg_wr(input logic [6:0] a, input logic [7:0] v);
    @(negedge CLK_I);
    {wr, addr, wdata} = {1'b1, a, v};
    @(negedge CLK_I);
    wr = 1'b0;
  endtask : reg_wr
  task automatic reg_rd(input logic [6:0] a, output logic [7:0] v);
    @(negedge CLK_I);
    {rd, addr} = {1'b1, a};
    @(negedge CLK_I);
    rd = 1'b0;
    v = rdata;
  endtask : reg_rd
  task automatic pulse(ref logic s);
    @(negedge CLK_I);
    s = 1'b1;
    @(negedge CLK_I);
    s = 1'b0;
  endtask : pulse

  // watchdog sized well beyond the expected run of about 12.4k cycles
  initial
  begin
    #500000;
    err_count++;
    wrap_up;
  end

  initial
  begin
    {wr, rd, addr, wdata, clr, tx_start, tape} = '0;
    wb_last = 1'b0;
    RST_N_I = 1'b0;
    void'($urandom(32'haa8d));
    cs_a = 40'({$urandom, $urandom}) | 40'h1;
    cs_b = cs_a ^ 40'h1_0000_0000;
    do_reset;
    reg_rd(SUT_ADDR_RX_BUF, q);
    chk(q, 0);
    chk({tx_mul, rx_mul, clk_sel, tx_run}, 10'b001_001_001_0);
    reg_wr(SUT_ADDR_RX_BUF, 8'hff);
    reg_wr(7'h0d, 8'hff);
    reg_rd(SUT_ADDR_RX_BUF, q);
    chk(q, 8'h3f);
    reg_rd(7'h0d, q);
    chk(q, 0);
    // legal codes only, reserved bit 7 random
    for (int i = 0; i < 12; i++)
    begin
      c = $urandom % 3;
      r = codes[$urandom % 5];
      d = {1'($urandom), 1'($urandom), r, 2'(c), 1'($urandom)};
      reg_wr(SUT_ADDR_TX_CTL, d);
      chk(clk_sel, 3'h1 << c);
      chk(tx_mul, mt[r]);
      chk(rx_mul, mr[r]);
      chk(tx_run, d[0]);
      reg_rd(SUT_ADDR_TX_CTL, q);
      chk(q, d & 8'h7f);
    end
    // validity follows the field only while running
    foreach (codes[i])
    begin
      d = {1'b0, 1'($urandom), 5'h00, 1'($urandom)};
      reg_wr(SUT_ADDR_TX_CTL, d);
      pulse(tx_start);
      chk(tx_val, d[6] & d[0]);
    end
    // user buffer modes, sizes and block flag in mode 0
    for (int k = 0; k < 5; k++)
    begin
      m = cfgs[k][2:1];
      ln = (m == 1 && cfgs[k][0]) ? 768 : 384;
      ew = (m == 0) ? 0 : 2 * frs[k];
      reg_wr(SUT_ADDR_RX_BUF, cfgs[k]);
      pulse(clr);
      n_wr = 0;
      n_b = 0;
      n_irq = 0;
      n_tog = 0;
      src.block(frs[k], cs_a);
      @(negedge CLK_I);
      chk(n_wr, ew);
      chk(n_b, (cfgs[k][4] && m != 0) ? frs[k] : 0);
      if (!cfgs[k][4]) chk(n_irq, ew / ln);
      if (!cfgs[k][4] && n_irq > 0) chk(last_a, ln - 1);
      src.block(1, cs_a);
      @(negedge CLK_I);
      chk(cs_flag, frs[k] == 192);
      chk(n_tog, ew / ln);
      chk(fmt_pro, m == 2);
    end
    // change-only flag mode: first block, repeat, then a changed block
    do_reset;
    reg_wr(SUT_ADDR_RX_BUF, 8'h0a);
    src.block(192, cs_a);
    src.block(192, cs_a);
    chk(cs_flag, 1);
    pulse(clr);
    src.block(192, cs_a);
    src.block(192, cs_b);
    chk(cs_flag, 0);
    src.block(1, cs_b);
    @(negedge CLK_I);
    chk(cs_flag, 1);
    // tape id-only mode on consumer blocks: interrupt only when the start bit flips
    reg_wr(SUT_ADDR_RX_BUF, 8'h24);
    tape = 1'b1;
    zq.delete();
    src.block(192, cs_a & ~40'h1);
    @(negedge CLK_I);
    n_irq = 0;
    repeat (5) src.block(192, cs_a & ~40'h1);
    @(negedge CLK_I);
    ew = 0;
    for (int i = 1; i < 6; i++) ew += int'(zq[i] != zq[i - 1]);
    chk(n_irq, ew);
    chk(fmt_pro, 0);
    wrap_up;
  end
endmodule : spdif_user_buffer_tx_control_test
`default_nettype wire
